/* logic/i2ce_pkg.sv */
// i2ce_pkg: register map, event bit positions and counts for the event flags
// assumes: a 32-bit apb slave with byte-addressed word registers
package i2ce_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0]  OFF_EVENT = 8'h00;
    localparam logic [7:0]  OFF_SNAP  = 8'h04;
    localparam logic [7:0]  OFF_NEW   = 8'h08;
    localparam logic [7:0]  OFF_ISTAT = 8'h0c;
    localparam logic [7:0]  OFF_CTRL  = 8'h10;
    localparam logic [7:0]  OFF_WADDR = 8'h14;
    localparam logic [7:0]  OFF_WDATA = 8'h18;

    // event bit positions
    localparam int B_DIAG_TIMER   = 5;
    localparam int B_DIAG_HIST    = 6;
    localparam int B_DIAG_CMD     = 7;
    localparam int B_INBOX        = 8;
    localparam int B_OUTBOX       = 9;
    localparam int B_SLV_COL      = 11;
    localparam int B_SLV_TRANS_TO = 12;
    localparam int B_SLV_BYTE_TO  = 13;
    localparam int B_SLV_SCL_TO   = 14;
    localparam int B_MST_DONE     = 17;
    localparam int B_BOOT_TO      = 19;
    localparam int B_BOOT_ERR     = 20;
    localparam int B_BOOT_SIZE    = 21;
    localparam int B_BOOT_NODEV   = 22;
    localparam int B_MST_NACK     = 26;
    localparam int B_MST_COL      = 27;
    localparam int B_MST_SCL_TO   = 30;

    // control register field
    localparam int B_SRST = 0;

    // reset values and masks
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] EV_IMPL  = 32'h4c7a_7be0;
    localparam logic [47:0] CNT_PAD  = 48'hffff_ffff_ffff;

    // counts
    localparam int HIST_DEPTH = 8;
    localparam int NOD_TRIES  = 6;

endpackage : i2ce_pkg

/* logic/i2ce_event_flags.sv */
// i2ce_event_flags: event flag bank of an i2c controller with apb access
// assumes: event pulses come from logic on clk, one cycle wide
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module i2ce_event_flags
    import i2ce_pkg::*;
#(
    parameter int HIST_N = HIST_DEPTH,
    parameter int NOD_N  = NOD_TRIES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // diagnostic engine
    input  wire logic        diag_timer_p,
    input  wire logic        hist_entry_p,
    input  wire logic        diag_cmd_done_p,
    // slave interface
    input  wire logic        slave_ext_active,
    input  wire logic        inbox_written_p,
    input  wire logic        outbox_read_p,
    input  wire logic        outbox_full,
    input  wire logic        slave_bit_check_p,
    input  wire logic        slave_drive_one,
    input  wire logic        slave_sda_seen,
    input  wire logic        slave_trans_timer_p,
    input  wire logic        slave_byte_timer_p,
    input  wire logic        slave_scl_timer_p,
    // master interface
    input  wire logic        master_sw_done_p,
    // boot load sequencer
    input  wire logic        boot_active,
    input  wire logic        boot_nack_p,
    input  wire logic        boot_scl_to_p,
    input  wire logic        boot_col_p,
    input  wire logic        boot_cnt_p,
    input  wire logic [47:0] boot_cnt_pad,
    input  wire logic        boot_cnt_bad_p,
    input  wire logic [31:0] boot_cnt_val,
    input  wire logic        boot_addr_nack_p,
    input  wire logic        boot_rd_p,
    input  wire logic [31:0] boot_rd_addr,
    input  wire logic [31:0] boot_rd_data,
    // status out
    output logic             boot_stop,
    output logic             block_soft_reset
);

    // parameter checks at elaboration
    if (HIST_N < 2 || HIST_N > 256) begin : g_bad_hist
        $error("HIST_N out of range");
    end
    if (NOD_N < 2 || NOD_N > 256) begin : g_bad_nod
        $error("NOD_N out of range");
    end

    logic [31:0] new_q, snap_q, ev_set;
    logic [31:0] ext_waddr_q, ext_wdata_q;
    logic [7:0]  hist_cnt_q, nod_cnt_q;
    logic        srst_q, stop_q;
    logic        acc, wr_acc, rd_acc;
    logic        boot_err, boot_pad_bad;

    // apb access: answered one cycle into the access phase
    assign acc    = psel && penable && !pready;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;

    // boot error sources
    assign boot_pad_bad = boot_cnt_p && (boot_cnt_pad != CNT_PAD);
    assign boot_err = boot_active && !stop_q &&
        (boot_nack_p || boot_scl_to_p || boot_col_p || boot_pad_bad);

    // hardware set vector
    always_comb begin
        ev_set = RST_WORD;
        ev_set[B_DIAG_TIMER]   = diag_timer_p && !boot_active;
        ev_set[B_BOOT_TO]      = diag_timer_p && boot_active;
        ev_set[B_DIAG_HIST]    = hist_entry_p &&
            (hist_cnt_q == 8'(HIST_N - 1));
        ev_set[B_DIAG_CMD]     = diag_cmd_done_p;
        ev_set[B_INBOX]        = inbox_written_p;
        ev_set[B_OUTBOX]       = outbox_read_p && outbox_full;
        ev_set[B_SLV_COL]      = slave_ext_active && slave_bit_check_p &&
            slave_drive_one && !slave_sda_seen;
        ev_set[B_SLV_TRANS_TO] = slave_ext_active && slave_trans_timer_p;
        ev_set[B_SLV_BYTE_TO]  = slave_ext_active && slave_byte_timer_p;
        ev_set[B_SLV_SCL_TO]   = slave_ext_active && slave_scl_timer_p;
        ev_set[B_MST_DONE]     = master_sw_done_p && !boot_active;
        ev_set[B_BOOT_ERR]     = boot_err;
        ev_set[B_MST_NACK]     = boot_err && boot_nack_p;
        ev_set[B_MST_COL]      = boot_err && boot_col_p;
        ev_set[B_MST_SCL_TO]   = boot_err && boot_scl_to_p;
        ev_set[B_BOOT_SIZE]    = boot_active && !stop_q && boot_cnt_bad_p;
        ev_set[B_BOOT_NODEV]   = boot_active && !stop_q && boot_addr_nack_p &&
            (nod_cnt_q == 8'(NOD_N - 1));
        if (srst_q) begin
            ev_set = RST_WORD;
        end
    end

    // diagnostic history entry counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hist_cnt_q <= 8'h00;
        end else if (srst_q) begin
            hist_cnt_q <= 8'h00;
        end else if (hist_entry_p) begin
            hist_cnt_q <= (hist_cnt_q == 8'(HIST_N - 1)) ? 8'h00 : hist_cnt_q + 8'h01;
        end
    end

    // boot addressing nack counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nod_cnt_q <= 8'h00;
        end else if (srst_q || !boot_active) begin
            nod_cnt_q <= 8'h00;
        end else if (boot_addr_nack_p && nod_cnt_q != 8'(NOD_N - 1)) begin
            nod_cnt_q <= nod_cnt_q + 8'h01;
        end
    end

    // boot stop and visible last address and data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_q      <= 1'b0;
            ext_waddr_q <= RST_WORD;
            ext_wdata_q <= RST_WORD;
        end else if (srst_q) begin
            stop_q      <= 1'b0;
            ext_waddr_q <= RST_WORD;
            ext_wdata_q <= RST_WORD;
        end else if (boot_active && !stop_q) begin
            if (boot_err || ev_set[B_BOOT_SIZE] || ev_set[B_BOOT_NODEV]) begin
                stop_q <= 1'b1;
            end
            if (ev_set[B_BOOT_SIZE]) begin
                ext_waddr_q <= boot_cnt_val;
            end else if (boot_rd_p) begin
                ext_waddr_q <= boot_rd_addr;
                ext_wdata_q <= boot_rd_data;
            end
        end
    end

    // soft reset control bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srst_q <= 1'b0;
        end else if (wr_acc && paddr == OFF_CTRL) begin
            srst_q <= pwdata[B_SRST];
        end
    end

    // new event bits: w1s, cleared by event write or snapshot
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            new_q <= RST_WORD;
        end else if (srst_q) begin
            new_q <= RST_WORD;
        end else if (rd_acc && paddr == OFF_ISTAT) begin
            new_q <= ev_set;
        end else if (wr_acc && paddr == OFF_EVENT) begin
            new_q <= (new_q & ~(pwdata & EV_IMPL)) | ev_set;
        end else if (wr_acc && paddr == OFF_NEW) begin
            new_q <= new_q | (pwdata & EV_IMPL) | ev_set;
        end else begin
            new_q <= new_q | ev_set;
        end
    end

    // snapshot bits: taken on status read, w1c
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap_q <= RST_WORD;
        end else if (srst_q) begin
            snap_q <= RST_WORD;
        end else if (rd_acc && paddr == OFF_ISTAT) begin
            snap_q <= snap_q | new_q;
        end else if (wr_acc && (paddr == OFF_EVENT || paddr == OFF_SNAP ||
                                paddr == OFF_ISTAT)) begin
            snap_q <= snap_q & ~(pwdata & EV_IMPL);
        end
    end

    // apb answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RST_WORD;
        end else begin
            pready  <= acc;
            pslverr <= 1'b0;
            prdata  <= RST_WORD;
            if (acc) begin
                case (paddr)
                    OFF_EVENT, OFF_ISTAT: begin
                        prdata <= (new_q | snap_q) & EV_IMPL;
                    end
                    OFF_SNAP: begin
                        prdata <= snap_q & EV_IMPL;
                    end
                    OFF_NEW: begin
                        prdata <= new_q & EV_IMPL;
                    end
                    OFF_CTRL: begin
                        prdata[B_SRST] <= srst_q;
                    end
                    OFF_WADDR: begin
                        prdata <= ext_waddr_q;
                    end
                    OFF_WDATA: begin
                        prdata <= ext_wdata_q;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
                if (pwrite) begin
                    prdata <= RST_WORD;
                end
            end
        end
    end

    assign boot_stop        = stop_q;
    assign block_soft_reset = srst_q;

    // checks
    sequence s_live;
        !srst_q && !wr_acc;
    endsequence

    sequence s_slave_collision_cause;
        slave_ext_active && slave_bit_check_p && slave_drive_one && !slave_sda_seen;
    endsequence

    sequence s_boot_stopped;
        stop_q && !srst_q;
    endsequence

    AST_DIAG_TIMER_SET: assert property (@(posedge clk) disable iff (!rstn)
        (diag_timer_p && !boot_active && !srst_q) |=> new_q[B_DIAG_TIMER])
        else $error("diag timer flag not set");

    AST_DIAG_TIMER_BOOT: assert property (@(posedge clk) disable iff (!rstn)
        (diag_timer_p && boot_active && !new_q[B_DIAG_TIMER] && !srst_q && !wr_acc)
        |=> new_q[B_BOOT_TO] && !new_q[B_DIAG_TIMER])
        else $error("boot timer routed wrong");

    AST_HIST_EIGHTH: assert property (@(posedge clk) disable iff (!rstn)
        (hist_entry_p && hist_cnt_q != 8'(HIST_N - 1) && !new_q[B_DIAG_HIST] && !srst_q && !wr_acc)
        |=> !new_q[B_DIAG_HIST])
        else $error("history flag early");

    AST_HIST_SET: assert property (@(posedge clk) disable iff (!rstn)
        (hist_entry_p && hist_cnt_q == 8'(HIST_N - 1) && !srst_q) |=> new_q[B_DIAG_HIST])
        else $error("history flag missed");

    AST_DIAG_CMD_SET: assert property (@(posedge clk) disable iff (!rstn)
        (diag_cmd_done_p && !srst_q) |=> new_q[B_DIAG_CMD])
        else $error("diag command flag missed");

    AST_INBOX_SET: assert property (@(posedge clk) disable iff (!rstn)
        (inbox_written_p && !srst_q) |=> new_q[B_INBOX])
        else $error("inbox flag missed");

    AST_OUTBOX_FULL: assert property (@(posedge clk) disable iff (!rstn)
        (outbox_read_p && !outbox_full && !new_q[B_OUTBOX] && !ev_set[B_OUTBOX] && !wr_acc)
        |=> !new_q[B_OUTBOX])
        else $error("outbox flag without full");

    AST_SLV_COL: assert property (@(posedge clk) disable iff (!rstn)
        (s_slave_collision_cause and s_live) |=> new_q[B_SLV_COL])
        else $error("slave collision missed");

    AST_MST_DONE_SET: assert property (@(posedge clk) disable iff (!rstn)
        (master_sw_done_p && !boot_active && !srst_q) |=> new_q[B_MST_DONE])
        else $error("master done flag missed");

    AST_BOOT_ERR_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
        (boot_err && boot_nack_p && !srst_q) |=> new_q[B_BOOT_ERR] && new_q[B_MST_NACK] && boot_stop)
        else $error("boot error cause missing");

    AST_BOOT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        s_boot_stopped |=> $stable(ext_waddr_q) && $stable(ext_wdata_q))
        else $error("boot capture moved after stop");

    AST_BOOT_SIZE_COUNT: assert property (@(posedge clk) disable iff (!rstn)
        (ev_set[B_BOOT_SIZE]) |=> new_q[B_BOOT_SIZE] && ext_waddr_q == $past(boot_cnt_val) && boot_stop)
        else $error("size error not captured");

    AST_NOD: assert property (@(posedge clk) disable iff (!rstn)
        (boot_addr_nack_p && boot_active && !stop_q && !srst_q && nod_cnt_q == 8'(NOD_N - 1))
        |=> new_q[B_BOOT_NODEV])
        else $error("no device flag missed");

    AST_W1C: assert property (@(posedge clk) disable iff (!rstn)
        (wr_acc && paddr == OFF_EVENT && ev_set == RST_WORD)
        |=> ((new_q | snap_q) & $past(pwdata)) == RST_WORD)
        else $error("event write did not clear");

    AST_SNAPSHOT: assert property (@(posedge clk) disable iff (!rstn)
        (rd_acc && paddr == OFF_ISTAT && !srst_q)
        |=> ((snap_q & $past(new_q)) == $past(new_q)) && new_q == $past(ev_set))
        else $error("snapshot lost events");

    AST_SRST: assert property (@(posedge clk) disable iff (!rstn)
        srst_q |=> new_q == RST_WORD && snap_q == RST_WORD)
        else $error("soft reset left flags");

    AST_RSVD: assert property (@(posedge clk) disable iff (!rstn)
        ((new_q | snap_q) & ~EV_IMPL) == RST_WORD)
        else $error("reserved bit set");

endmodule : i2ce_event_flags

`default_nettype wire

/* testbench/i2ce_far_model.sv */
// i2ce_far_model: far-side event sources, one-cycle pulses on clk
// assumes: the bench picks a source by index and strobes go for one cycle
`timescale 1ns/1ps
`default_nettype none

module i2ce_far_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // pulse request
    input  wire logic [4:0]  code,
    input  wire logic        go,
    // event pulses
    output logic      [16:0] ev
);
    // one pulse per request, gone the next cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev <= 17'h0_0000;
        end else begin
            ev <= go ? (17'h0_0001 << code) : 17'h0_0000;
        end
    end
endmodule : i2ce_far_model

`default_nettype wire

/* testbench/i2c_event_flag_bits_test.sv */
// i2c_event_flag_bits_test: self-checking bench for the event flag bank
// assumes: i2ce_pkg, i2ce_event_flags and i2ce_far_model are compiled first
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module i2c_event_flag_bits_test
    import i2ce_pkg::*;
();
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cval, raddr, rdata;
    logic        ext, full, drv1, sda, boot, go, bstop, srst;
    logic [47:0] pad;
    logic [4:0]  code;
    logic [16:0] ev;
    int          fail_count, n_compared, cyc;

    i2ce_event_flags #(.HIST_N(HIST_DEPTH), .NOD_N(NOD_TRIES)) DUT (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .diag_timer_p(ev[0]), .hist_entry_p(ev[1]), .diag_cmd_done_p(ev[2]),
        .slave_ext_active(ext), .inbox_written_p(ev[3]), .outbox_read_p(ev[4]),
        .outbox_full(full), .slave_bit_check_p(ev[5]), .slave_drive_one(drv1),
        .slave_sda_seen(sda), .slave_trans_timer_p(ev[6]), .slave_byte_timer_p(ev[7]),
        .slave_scl_timer_p(ev[8]), .master_sw_done_p(ev[9]), .boot_active(boot),
        .boot_nack_p(ev[10]), .boot_scl_to_p(ev[11]), .boot_col_p(ev[12]),
        .boot_cnt_p(ev[13]), .boot_cnt_pad(pad), .boot_cnt_bad_p(ev[14]),
        .boot_cnt_val(cval), .boot_addr_nack_p(ev[15]), .boot_rd_p(ev[16]),
        .boot_rd_addr(raddr), .boot_rd_data(rdata), .boot_stop(bstop), .block_soft_reset(srst));

    i2ce_far_model far (.clk(clk), .rstn(rstn), .code(code), .go(go), .ev(ev));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // apb transfer: setup, access until pready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr32

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask : rchk

    task automatic pulse(input int c);
        code <= c[4:0];
        go   <= 1'b1;
        @(posedge clk);
        go   <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    // pulse one source, compare the whole event word, then clear it
    task automatic one(input int c, input logic [31:0] e, input string nm);
        pulse(c);
        rchk(OFF_EVENT, e, nm);
        wr32(OFF_EVENT, 32'hffff_ffff);
    endtask : one

    task automatic srel();
        wr32(OFF_CTRL, 32'h0000_0001);
        wr32(OFF_CTRL, 32'h0000_0000);
    endtask : srel

    task automatic t_regs();
        rchk(OFF_EVENT, RST_WORD, "event reset");
        wr32(OFF_NEW, 32'hffff_ffff);
        rchk(OFF_EVENT, EV_IMPL, "reserved bits");
        wr32(OFF_EVENT, 32'h0000_0000);
        rchk(OFF_EVENT, EV_IMPL, "write zero keeps");
        wr32(OFF_EVENT, 32'h0000_0100);
        rchk(OFF_EVENT, EV_IMPL & 32'hffff_feff, "clear one bit");
        wr32(OFF_EVENT, 32'hffff_ffff);
        rchk(OFF_EVENT, 32'h0000_0000, "clear all");
        apb(1'b0, 8'h1c, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, er)
        $display("test regs done");
    endtask : t_regs

    task automatic t_events();
        int cs[8] = '{0, 2, 3, 4, 6, 7, 8, 9};
        int bs[8] = '{B_DIAG_TIMER, B_DIAG_CMD, B_INBOX, B_OUTBOX,
                      B_SLV_TRANS_TO, B_SLV_BYTE_TO, B_SLV_SCL_TO, B_MST_DONE};
        for (int i = 0; i < 8; i++) begin
            one(cs[i], 32'h0000_0001 << bs[i], "single event");
        end
        full <= 1'b0;
        ext  <= 1'b0;
        @(posedge clk);
        one(4, 32'h0000_0000, "outbox not full");
        for (int i = 6; i < 9; i++) begin
            one(i, 32'h0000_0000, "timer without slave");
        end
        one(5, 32'h0000_0000, "collision without slave");
        ext  <= 1'b1;
        @(posedge clk);
        one(5, 32'h0000_0001 << B_SLV_COL, "collision");
        sda  <= 1'b1;
        @(posedge clk);
        one(5, 32'h0000_0000, "bus high");
        drv1 <= 1'b0;
        sda  <= 1'b0;
        @(posedge clk);
        one(5, 32'h0000_0000, "drove zero");
        repeat (HIST_DEPTH - 1) pulse(1);
        rchk(OFF_EVENT, 32'h0000_0000, "history short");
        one(1, 32'h0000_0001 << B_DIAG_HIST, "history eighth");
        $display("test events done");
    endtask : t_events

    task automatic t_snap();
        pulse(3);
        rchk(OFF_ISTAT, 32'h0000_0100, "status read");
        rchk(OFF_NEW, 32'h0000_0000, "new after snapshot");
        rchk(OFF_SNAP, 32'h0000_0100, "snapshot");
        rchk(OFF_EVENT, 32'h0000_0100, "event is or");
        wr32(OFF_SNAP, 32'h0000_0100);
        rchk(OFF_EVENT, 32'h0000_0000, "snapshot cleared");
        pulse(3);
        rchk(OFF_ISTAT, 32'h0000_0100, "second status read");
        wr32(OFF_ISTAT, 32'h0000_0100);
        rchk(OFF_EVENT, 32'h0000_0000, "status write clears");
        pulse(3);
        wr32(OFF_CTRL, 32'h0000_0001);
        `CHK("soft reset out", 1'b1, srst)
        rchk(OFF_CTRL, 32'h0000_0001, "soft reset bit");
        rchk(OFF_EVENT, 32'h0000_0000, "soft reset clears");
        one(3, 32'h0000_0000, "soft reset blocks");
        wr32(OFF_CTRL, 32'h0000_0000);
        $display("test snapshot done");
    endtask : t_snap

    task automatic t_boot();
        logic [31:0] es[4] = '{32'h0410_0000, 32'h4010_0000, 32'h0810_0000, 32'h0010_0000};
        boot <= 1'b1;
        @(posedge clk);
        one(0, 32'h0000_0001 << B_BOOT_TO, "timer in boot");
        one(13, 32'h0000_0000, "count pad good");
        pad  <= 48'hffff_ffff_fffe;
        for (int i = 0; i < 4; i++) begin
            raddr <= 32'h0000_00a0 + i;
            rdata <= 32'h5a5a_0c30 ^ i;
            pulse(16);
            one(10 + i, es[i], "boot error cause");
            `CHK("boot stop", 1'b1, bstop)
            rchk(OFF_WADDR, raddr, "last address");
            rchk(OFF_WDATA, rdata, "last data");
            one(10 + i, 32'h0000_0000, "stopped");
            srel();
        end
        one(14, 32'h0000_0001 << B_BOOT_SIZE, "size error");
        `CHK("size stop", 1'b1, bstop)
        rchk(OFF_WADDR, cval, "count shown");
        srel();
        repeat (NOD_TRIES - 1) pulse(15);
        rchk(OFF_EVENT, 32'h0000_0000, "few address nacks");
        one(15, 32'h0000_0001 << B_BOOT_NODEV, "no device");
        boot <= 1'b0;
        srel();
        $display("test boot done");
    endtask : t_boot

    initial begin
        fail_count = 0;
        n_compared = 0;
        cyc     = 0;
        rstn    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        ext     = 1'b1;
        full    = 1'b1;
        drv1    = 1'b1;
        sda     = 1'b0;
        boot    = 1'b0;
        go      = 1'b0;
        code    = 5'h00;
        pad     = CNT_PAD;
        cval    = 32'h0000_0123;
        raddr   = 32'h0000_0000;
        rdata   = 32'h0000_0000;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_events();
        t_snap();
        t_boot();
        test_done();
    end
endmodule : i2c_event_flag_bits_test

`default_nettype wire
